// ===== channel_clock_divider_pkg.sv
package channel_clock_divider_pkg;

    // ========================================
    // Register bus geometry
    localparam int ADDR_WIDTH = 10;
    localparam int DATA_WIDTH = 8;

    // ========================================
    // Register offsets
    localparam logic [ADDR_WIDTH-1:0] DRIVER_EIGHT_GATE_ADDR    = 10'h0fc;
    localparam logic [ADDR_WIDTH-1:0] DRIVER_EIGHT_POLARITY_ADDR = 10'h0f0;
    localparam logic [ADDR_WIDTH-1:0] DIVIDER_STATUS_ADDR       = 10'h0f1;
    localparam logic [ADDR_WIDTH-1:0] DIVIDER_PHASE_COUNTS_ADDR = 10'h190;
    localparam logic [ADDR_WIDTH-1:0] DIVIDER_MODE_CONTROL_ADDR = 10'h191;

    // ========================================
    // Field positions
    localparam int GATE_ON_LOCK_BIT  = 7;
    localparam int INVERT_BIT        = 0;
    localparam int LOW_COUNT_MSB     = 7;
    localparam int LOW_COUNT_LSB     = 4;
    localparam int HIGH_COUNT_MSB    = 3;
    localparam int HIGH_COUNT_LSB    = 0;
    localparam int BYPASS_BIT        = 7;
    localparam int IGNORE_SYNC_BIT   = 6;
    localparam int FORCE_BIT         = 5;
    localparam int START_HIGH_BIT    = 4;

    // ========================================
    // Values after reset
    localparam logic [DATA_WIDTH-1:0] PHASE_COUNTS_RESET = 8'h77;
    localparam logic [DATA_WIDTH-1:0] MODE_CONTROL_RESET = 8'h00;
    localparam logic [DATA_WIDTH-1:0] GATE_RESET         = 8'h00;
    localparam logic [DATA_WIDTH-1:0] POLARITY_RESET     = 8'h00;
    localparam logic [3:0]            COUNT_RESET        = 4'h0;

    // ========================================
    // Divider operating modes
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SYNC_HOLD,
        MODE_FORCED,
        MODE_BYPASS
    } divider_mode_type;

endpackage

// ===== channel_clock_divider.sv
// What this block does
// - With the gate-on-lock option set, driver eight is enabled only while the lock gate is high.
// - The low phase lasts the low count field plus one input cycles, eight after reset.
// - The high phase lasts the high count field plus one input cycles, eight after reset.
// - The bypass bit makes the divider output toggle every input cycle instead of dividing.
// - The ignore-sync bit decides whether the chip synchronisation signal is obeyed.
// - Forcing needs ignore-sync and then drives the output to the start-level bit.
// - Forcing has no effect in bypass while polarity inversion still works.
// - The start-level bit chooses the level at which toggling begins.
// - Start level 0 begins low and 1 begins high, with 0 after reset.
`timescale 1ns/1ps
module channel_clock_divider (
    input  wire logic                                            ref_clk,
    input  wire logic                                            resetn,
    input  wire logic [channel_clock_divider_pkg::ADDR_WIDTH-1:0] regAddr,
    input  wire logic [channel_clock_divider_pkg::DATA_WIDTH-1:0] wrData,
    input  wire logic                                            wrStrobe,
    input  wire logic                                            rdStrobe,
    output logic      [channel_clock_divider_pkg::DATA_WIDTH-1:0] rdData,
    input  wire logic                                            syncRequest,
    input  wire logic                                            lockDetectGateSignal,
    output logic                                                 dividerOut,
    output logic                                                 clockOutputEight,
    output logic                                                 driverEightEnable
);
    import channel_clock_divider_pkg::*;

    // ========================================
    // Reset release
    logic rstMeta_q;
    logic rstSyncN;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_q <= 1'b0;
            rstSyncN  <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSyncN  <= rstMeta_q;
        end
    end

    // ========================================
    // Registers
    logic [DATA_WIDTH-1:0] phaseCounts_q, phaseCounts_d;
    logic [DATA_WIDTH-1:0] modeControl_q, modeControl_d;
    logic [DATA_WIDTH-1:0] gateCtrl_q, gateCtrl_d;
    logic [DATA_WIDTH-1:0] polarity_q, polarity_d;
    logic [DATA_WIDTH-1:0] rdData_q, rdData_d;
    divider_mode_type      mode_q, mode_d;
    logic [3:0]            count_q, count_d;
    logic                  phaseHigh_q, phaseHigh_d;
    logic                  outEight_q, outEight_d;
    logic                  enEight_q, enEight_d;
    logic [3:0]            lowLen;
    logic [3:0]            highLen;
    logic                  startHigh;

    assign lowLen    = phaseCounts_q[LOW_COUNT_MSB:LOW_COUNT_LSB];
    assign highLen   = phaseCounts_q[HIGH_COUNT_MSB:HIGH_COUNT_LSB];
    assign startHigh = modeControl_q[START_HIGH_BIT];

    always_comb begin
        phaseCounts_d = phaseCounts_q;
        modeControl_d = modeControl_q;
        gateCtrl_d    = gateCtrl_q;
        polarity_d    = polarity_q;
        rdData_d      = '0;
        if (wrStrobe) begin
            case (regAddr)
                DIVIDER_PHASE_COUNTS_ADDR:  phaseCounts_d = wrData;
                DIVIDER_MODE_CONTROL_ADDR:  modeControl_d = wrData;
                DRIVER_EIGHT_GATE_ADDR:     gateCtrl_d    = wrData & 8'h80;
                DRIVER_EIGHT_POLARITY_ADDR: polarity_d    = wrData & 8'h01;
                default: ;
            endcase
        end
        if (rdStrobe) begin
            case (regAddr)
                DIVIDER_PHASE_COUNTS_ADDR:  rdData_d = phaseCounts_q;
                DIVIDER_MODE_CONTROL_ADDR:  rdData_d = modeControl_q;
                DRIVER_EIGHT_GATE_ADDR:     rdData_d = gateCtrl_q;
                DRIVER_EIGHT_POLARITY_ADDR: rdData_d = polarity_q;
                DIVIDER_STATUS_ADDR:        rdData_d = {3'h0, enEight_q, mode_q, 1'b0, phaseHigh_q};
                default:                    rdData_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            phaseCounts_q <= PHASE_COUNTS_RESET;
            modeControl_q <= MODE_CONTROL_RESET;
            gateCtrl_q    <= GATE_RESET;
            polarity_q    <= POLARITY_RESET;
            rdData_q      <= '0;
        end else begin
            phaseCounts_q <= phaseCounts_d;
            modeControl_q <= modeControl_d;
            gateCtrl_q    <= gateCtrl_d;
            polarity_q    <= polarity_d;
            rdData_q      <= rdData_d;
        end
    end

    // ========================================
    // Divider core
    // Bypass cannot hand the raw clock through a flip-flop, so the output toggles every
    // input cycle, which is the fastest square wave this single-clock design can make.
    always_comb begin
        if (modeControl_q[BYPASS_BIT]) begin
            mode_d = MODE_BYPASS;
        end else if (modeControl_q[IGNORE_SYNC_BIT] && modeControl_q[FORCE_BIT]) begin
            mode_d = MODE_FORCED;
        end else if (!modeControl_q[IGNORE_SYNC_BIT] && syncRequest) begin
            mode_d = MODE_SYNC_HOLD;
        end else begin
            mode_d = MODE_RUN;
        end
        count_d     = COUNT_RESET;
        phaseHigh_d = phaseHigh_q;
        case (mode_d)
            MODE_BYPASS: begin
                phaseHigh_d = !phaseHigh_q;
            end
            MODE_FORCED: begin
                phaseHigh_d = startHigh;
            end
            MODE_SYNC_HOLD: begin
                phaseHigh_d = startHigh;
            end
            MODE_RUN: begin
                // Ending at or past the length stops a shortened count from running to a wrap.
                if (count_q >= (phaseHigh_q ? highLen : lowLen)) begin
                    phaseHigh_d = !phaseHigh_q;
                end else begin
                    count_d = count_q + 4'h1;
                end
            end
            default: begin
                phaseHigh_d = 1'b0;
            end
        endcase
        enEight_d  = !gateCtrl_q[GATE_ON_LOCK_BIT] || lockDetectGateSignal;
        outEight_d = enEight_d && (phaseHigh_d ^ polarity_q[INVERT_BIT]);
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            mode_q      <= MODE_RUN;
            count_q     <= COUNT_RESET;
            phaseHigh_q <= 1'b0;
            outEight_q  <= 1'b0;
            enEight_q   <= 1'b1;
        end else begin
            mode_q      <= mode_d;
            count_q     <= count_d;
            phaseHigh_q <= phaseHigh_d;
            outEight_q  <= outEight_d;
            enEight_q   <= enEight_d;
        end
    end

    assign rdData            = rdData_q;
    assign dividerOut        = phaseHigh_q;
    assign clockOutputEight  = outEight_q;
    assign driverEightEnable = enEight_q;

    // ========================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstSyncN);

    logic runStay;
    // The first edge after reset still finds the core held, so no step is expected there.
    assign runStay = rstSyncN && (mode_q == MODE_RUN) && (mode_d == MODE_RUN);

    chk_gate_enable: assert property (
        gateCtrl_q[GATE_ON_LOCK_BIT] && !lockDetectGateSignal |=> !driverEightEnable
            && !clockOutputEight)
        else $error("Driver eight enabled without lock gate.");
    chk_low_hold: assert property (
        runStay && !phaseHigh_q && count_q < lowLen |=> !dividerOut
            && count_q == $past(count_q) + 4'h1)
        else $error("Low phase ended early.");
    chk_high_hold: assert property (
        runStay && phaseHigh_q && count_q < highLen |=> dividerOut)
        else $error("High phase ended early.");
    chk_phase_toggle: assert property (
        runStay && count_q >= (phaseHigh_q ? highLen : lowLen)
            |=> dividerOut != $past(dividerOut) && count_q == 4'h0)
        else $error("Phase did not alternate at its count.");
    chk_bypass_toggle: assert property (
        modeControl_q[BYPASS_BIT] ##1 modeControl_q[BYPASS_BIT] |-> $changed(dividerOut))
        else $error("Bypass output did not follow the input clock.");
    chk_sync_obeyed: assert property (
        !modeControl_q[BYPASS_BIT] && !modeControl_q[IGNORE_SYNC_BIT] && syncRequest
            |=> mode_q == MODE_SYNC_HOLD)
        else $error("Obeyed sync did not hold the divider.");
    chk_force_level: assert property (
        !modeControl_q[BYPASS_BIT] && modeControl_q[IGNORE_SYNC_BIT] && modeControl_q[FORCE_BIT]
            |=> dividerOut == $past(startHigh))
        else $error("Forced level wrong.");
    chk_force_bypass: assert property (
        modeControl_q[BYPASS_BIT] && modeControl_q[FORCE_BIT] |=> mode_q == MODE_BYPASS)
        else $error("Force acted during bypass.");
    // A start phase of length zero is already spent by the hold, so it turns at once.
    chk_sync_restart: assert property (
        mode_q == MODE_SYNC_HOLD && mode_d == MODE_RUN
            |-> count_q == 4'h0 && dividerOut == startHigh
            ##1 count_q == 4'h1 && dividerOut == $past(startHigh)
            || count_q == 4'h0 && dividerOut != $past(startHigh)
            && ($past(startHigh) ? $past(highLen) : $past(lowLen)) == 4'h0)
        else $error("Restart after sync began in the wrong phase.");

    cov_run_cycle: cover property (runStay && !phaseHigh_q ##1 runStay && phaseHigh_q);
    cov_sync_release: cover property (mode_q == MODE_SYNC_HOLD ##1 mode_q == MODE_RUN);
    cov_bypass: cover property (mode_q == MODE_BYPASS ##1 mode_q == MODE_BYPASS);
    cov_gate_closed: cover property (!driverEightEnable);

endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import channel_clock_divider_pkg::*;
    // ========================================
    // Stimulus and observation
    logic                  ref_clk = 1'b0;
    logic                  resetn  = 1'b0;
    logic [ADDR_WIDTH-1:0] regAddr = '0;
    logic [DATA_WIDTH-1:0] wrData  = '0;
    logic                  wrStrobe = 1'b0;
    logic                  rdStrobe = 1'b0;
    logic                  syncRequest = 1'b0;
    logic                  lockDetectGateSignal = 1'b1;
    logic [DATA_WIDTH-1:0] rdData;
    logic                  dividerOut;
    logic                  clockOutputEight;
    logic                  driverEightEnable;
    int                    err_count = 0;
    int                    cmp_count = 0;
    int                    cycles    = 0;

    channel_clock_divider u_dut (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .syncRequest(syncRequest), .lockDetectGateSignal(lockDetectGateSignal),
        .dividerOut(dividerOut), .clockOutputEight(clockOutputEight),
        .driverEightEnable(driverEightEnable));

    always #4 ref_clk = ~ref_clk;

    // ========================================
    // Shared tasks
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(logic [ADDR_WIDTH-1:0] a, logic [7:0] d);
        @(posedge ref_clk);
        wrStrobe <= 1'b1; regAddr <= a; wrData <= d;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
    endtask

    // Read data are valid only in the cycle after the strobe, so sample just after that edge.
    task automatic rd(logic [ADDR_WIDTH-1:0] a, logic [7:0] exp);
        @(posedge ref_clk);
        rdStrobe <= 1'b1; regAddr <= a;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        #1 check(rdData, exp);
    endtask

    // Called at a falling edge; counts falling edges until the level changes.
    task automatic run_len(output int n);
        logic v;
        v = dividerOut;
        n = 0;
        do begin
            n++;
            @(negedge ref_clk);
        end while (dividerOut === v && n < 40);
    endtask

    task automatic watch(output int t, output int ones);
        logic p;
        @(negedge ref_clk);
        p = dividerOut; t = 0; ones = 0;
        repeat (12) begin
            @(negedge ref_clk);
            if (dividerOut !== p) t++;
            if (dividerOut === 1'b1) ones++;
            p = dividerOut;
        end
    endtask

    // The first phase after release is skipped, since how much of the hold it counts is open.
    task automatic sync_run(logic [7:0] counts, logic [7:0] ctrl);
        int n;
        logic s;
        s = ctrl[START_HIGH_BIT];
        wr(DIVIDER_PHASE_COUNTS_ADDR, counts);
        wr(DIVIDER_MODE_CONTROL_ADDR, ctrl);
        @(posedge ref_clk) syncRequest <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) check(dividerOut, s);
        @(posedge ref_clk) syncRequest <= 1'b0;
        @(negedge ref_clk);
        run_len(n);
        check(dividerOut, !s);
        run_len(n);
        check(n[7:0], 8'(s ? counts[7:4] + 1 : counts[3:0] + 1));
        run_len(n);
        check(n[7:0], 8'(s ? counts[3:0] + 1 : counts[7:4] + 1));
        $display("sync run %h %h done", counts, ctrl);
    endtask

    // ========================================
    // Scenarios
    task automatic reg_test();
        @(negedge ref_clk);
        check(dividerOut, 1'b0);
        check(driverEightEnable, 1'b1);
        rd(DIVIDER_PHASE_COUNTS_ADDR, 8'h77);
        rd(DIVIDER_MODE_CONTROL_ADDR, 8'h00);
        rd(DRIVER_EIGHT_GATE_ADDR, 8'h00);
        rd(DRIVER_EIGHT_POLARITY_ADDR, 8'h00);
        rd(10'h3a5, 8'h00);
        $display("register test done");
    endtask

    // Short phases keep the twelve-cycle watch long enough to see several edges.
    task automatic mode_test();
        int t, ones;
        wr(DIVIDER_PHASE_COUNTS_ADDR, 8'h11);
        wr(DIVIDER_MODE_CONTROL_ADDR, 8'h40);
        syncRequest <= 1'b1;
        watch(t, ones);
        check(8'(t >= 4), 8'h01);
        @(posedge ref_clk) syncRequest <= 1'b0;
        wr(DIVIDER_MODE_CONTROL_ADDR, 8'h70);
        watch(t, ones);
        check(8'(ones), 8'h0c);
        rd(DIVIDER_STATUS_ADDR, 8'h19);
        wr(DIVIDER_MODE_CONTROL_ADDR, 8'h60);
        watch(t, ones);
        check(8'(ones), 8'h00);
        wr(DIVIDER_MODE_CONTROL_ADDR, 8'h30);
        watch(t, ones);
        check(8'(t >= 4), 8'h01);
        wr(DIVIDER_MODE_CONTROL_ADDR, 8'h80);
        watch(t, ones);
        check(8'(t), 8'h0c);
        wr(DIVIDER_MODE_CONTROL_ADDR, 8'hf0);
        watch(t, ones);
        check(8'(t), 8'h0c);
        $display("mode test done");
    endtask

    // Runs in bypass, where inversion must still reach driver eight.
    task automatic polarity_test();
        wr(DRIVER_EIGHT_POLARITY_ADDR, 8'h01);
        rd(DRIVER_EIGHT_POLARITY_ADDR, 8'h01);
        @(negedge ref_clk) check(clockOutputEight, !dividerOut);
        @(negedge ref_clk) check(clockOutputEight, !dividerOut);
        wr(DRIVER_EIGHT_POLARITY_ADDR, 8'h00);
        repeat (2) @(negedge ref_clk);
        check(clockOutputEight, dividerOut);
        $display("polarity test done");
    endtask

    task automatic gate_test();
        @(posedge ref_clk) lockDetectGateSignal <= 1'b0;
        wr(DRIVER_EIGHT_GATE_ADDR, 8'h80);
        rd(DRIVER_EIGHT_GATE_ADDR, 8'h80);
        repeat (3) @(negedge ref_clk);
        check(driverEightEnable, 1'b0);
        check(clockOutputEight, 1'b0);
        @(posedge ref_clk) lockDetectGateSignal <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check(driverEightEnable, 1'b1);
        wr(DRIVER_EIGHT_GATE_ADDR, 8'h00);
        @(posedge ref_clk) lockDetectGateSignal <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check(driverEightEnable, 1'b1);
        @(posedge ref_clk) lockDetectGateSignal <= 1'b1;
        $display("gate test done");
    endtask

    // ========================================
    // Run control
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // The ceiling is about twenty times what the scenarios need.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reg_test();
        sync_run(8'h77, 8'h00);
        sync_run(8'h21, 8'h00);
        sync_run(8'h21, 8'h10);
        sync_run(8'h0f, 8'h00);
        mode_test();
        polarity_test();
        gate_test();
        give_verdict();
    end
endmodule
